// *** instr_exec_pkg.sv ***
package instr_exec_pkg;
   // byte addresses on the register bus
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_PC = 8'h0C;
   localparam logic [7:0] ADDR_STACK_TOP = 8'h10;
   localparam logic [7:0] ADDR_CONFIG = 8'h14;
   localparam logic [7:0] ADDR_EXEC = 8'h18;
   localparam logic [7:0] ADDR_FILE_BASE = 8'h80;
   // field positions
   localparam int ZERO_BIT = 2;
   localparam int PAGE_LO = 5;
   localparam int PAGE_HI = 6;
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [10:0] PC_RST = 11'h7FF;
   localparam logic [7:0] CONFIG_RST = 8'hFF;
   localparam logic [10:0] STACK_TOP_RST = 11'h000;
   localparam logic [7:0] FILE_RST = 8'h00;
   // cycle counts
   localparam logic [1:0] CYCLES_ONE = 2'h1;
   localparam logic [1:0] CYCLES_TWO = 2'h2;
   // opcode values, 12-bit instruction word
   localparam logic [11:0] OP_NOP = 12'h000;
   localparam logic [11:0] OP_CONFIG_LOAD = 12'h002;
   localparam logic [6:0] OP_STORE_ACC = 7'h01;
   localparam logic [5:0] OP_OR_REG = 6'h04;
   localparam logic [5:0] OP_COPY_REG = 6'h08;
   localparam logic [3:0] OP_RETURN_LIT = 4'h8;
   localparam logic [2:0] OP_JUMP_ABS = 3'h5;
   localparam logic [3:0] OP_LOAD_LIT = 4'hC;
   localparam logic [3:0] OP_OR_LIT = 4'hD;

   typedef enum logic [3:0] {
      K_NOP, K_CONFIG_LOAD, K_STORE_ACC, K_OR_REG, K_COPY_REG,
      K_RETURN_LIT, K_JUMP_ABS, K_LOAD_LIT, K_OR_LIT, K_ILLEGAL
   } instr_kind_t;

   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] status;
      logic [10:0] pc;
   } core_state_t;
endpackage

// *** instr_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module instr_exec
   import instr_exec_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic busy_o
);

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} exec_state_t;

   function automatic logic [7:0] merge8(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] strb);
      merge8 = strb[0] ? d[7:0] : old;
   endfunction

   function automatic logic [10:0] merge11(input logic [10:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] strb);
      merge11 = {strb[1] ? d[10:8] : old[10:8],
                 strb[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic is_file(input logic [7:0] a);
      is_file = a[7] && (a[1:0] == 2'h0);
   endfunction

   core_state_t core_reg;
   logic [7:0] rf_reg [32];
   logic [10:0] stack_top_reg;
   logic [7:0] config_reg;
   logic [11:0] instr_reg;
   logic [1:0] cycles_reg;
   logic illegal_reg;
   exec_state_t state_reg;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic busy_reg;

   ////////////////////////////////////////////////////////////////////////
   // decode

   wire [4:0] f_addr = instr_reg[4:0];
   wire dest_file = instr_reg[5];
   wire [7:0] lit = instr_reg[7:0];
   wire [8:0] jump_k = instr_reg[8:0];
   wire [7:0] f_val = rf_reg[f_addr];
   wire [7:0] acc = core_reg.acc;

   instr_kind_t kind;
   assign kind =
      (instr_reg == OP_NOP) ? K_NOP :
      (instr_reg == OP_CONFIG_LOAD) ? K_CONFIG_LOAD :
      (instr_reg[11:5] == OP_STORE_ACC) ? K_STORE_ACC :
      (instr_reg[11:6] == OP_OR_REG) ? K_OR_REG :
      (instr_reg[11:6] == OP_COPY_REG) ? K_COPY_REG :
      (instr_reg[11:8] == OP_RETURN_LIT) ? K_RETURN_LIT :
      (instr_reg[11:9] == OP_JUMP_ABS) ? K_JUMP_ABS :
      (instr_reg[11:8] == OP_LOAD_LIT) ? K_LOAD_LIT :
      (instr_reg[11:8] == OP_OR_LIT) ? K_OR_LIT : K_ILLEGAL;

   wire two_cycle = (kind == K_JUMP_ABS) || (kind == K_RETURN_LIT);
   wire [7:0] or_lit_res = acc | lit;
   wire [7:0] or_reg_res = acc | f_val;
   wire [7:0] result = (kind == K_OR_LIT) ? or_lit_res :
                       (kind == K_OR_REG) ? or_reg_res : f_val;
   wire sets_zero = (kind == K_OR_LIT) || (kind == K_OR_REG) ||
                    (kind == K_COPY_REG);
   wire to_file = ((kind == K_OR_REG || kind == K_COPY_REG) && dest_file)
                  || (kind == K_STORE_ACC);
   wire to_acc = (kind == K_OR_LIT) || (kind == K_LOAD_LIT) ||
                 ((kind == K_OR_REG || kind == K_COPY_REG) && !dest_file) ||
                 (kind == K_RETURN_LIT);
   wire [7:0] acc_value = (kind == K_LOAD_LIT || kind == K_RETURN_LIT) ?
                          lit : result;
   wire [7:0] file_value = (kind == K_STORE_ACC) ? acc : result;

   // jump target: page bits from status sit above the operand
   wire [10:0] jump_pc =
      {core_reg.status[PAGE_HI:PAGE_LO], jump_k};
   wire [10:0] seq_pc = core_reg.pc + 11'h001;
   wire [10:0] next_pc = (kind == K_JUMP_ABS) ? jump_pc :
                         (kind == K_RETURN_LIT) ? stack_top_reg :
                         seq_pc;

   wire [7:0] status_exec = sets_zero ?
      {core_reg.status[7:ZERO_BIT+1], (result == 8'h00),
       core_reg.status[ZERO_BIT-1:0]} : core_reg.status;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire idle = (state_reg == ST_IDLE);
   wire wr_fire = awready_reg && s_axi_awvalid_i && wready_reg &&
                  s_axi_wvalid_i;
   wire wr_start = !awready_reg && !bvalid_reg && s_axi_awvalid_i &&
                   s_axi_wvalid_i && idle;
   wire rd_start = !arready_reg && !rvalid_reg && s_axi_arvalid_i;
   wire rd_fire = arready_reg && s_axi_arvalid_i;
   wire [7:0] wa = s_axi_awaddr_i;
   wire [7:0] ra = s_axi_araddr_i;
   wire wr_instr = wr_fire && (wa == ADDR_INSTR);
   wire wr_acc = wr_fire && (wa == ADDR_ACC);
   wire wr_status = wr_fire && (wa == ADDR_STATUS);
   wire wr_pc = wr_fire && (wa == ADDR_PC);
   wire wr_stack = wr_fire && (wa == ADDR_STACK_TOP);
   wire wr_file = wr_fire && is_file(wa);
   wire wr_ok = wr_instr || wr_acc || wr_status || wr_pc || wr_stack ||
                wr_file || (wa == ADDR_CONFIG) || (wa == ADDR_EXEC);

   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      if (ra == ADDR_INSTR) begin
         rd_mux = {20'h00000, instr_reg};
      end else if (ra == ADDR_ACC) begin
         rd_mux = {24'h000000, core_reg.acc};
      end else if (ra == ADDR_STATUS) begin
         rd_mux = {24'h000000, core_reg.status};
      end else if (ra == ADDR_PC) begin
         rd_mux = {21'h000000, core_reg.pc};
      end else if (ra == ADDR_STACK_TOP) begin
         rd_mux = {21'h000000, stack_top_reg};
      end else if (ra == ADDR_CONFIG) begin
         rd_mux = {24'h000000, config_reg};
      end else if (ra == ADDR_EXEC) begin
         rd_mux = {28'h0000000, illegal_reg, cycles_reg, busy_reg};
      end else if (is_file(ra)) begin
         rd_mux = {24'h000000, rf_reg[ra[6:2]]};
      end else begin
         rd_mux = 32'h00000000;
         rd_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus handshakes; writes are taken only while idle, so the
   // execution cycles never race a bus write on the same state

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
      end else if (ce_i) begin
         awready_reg <= wr_start;
         wready_reg <= wr_start;
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
      end else if (ce_i) begin
         arready_reg <= rd_start;
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing

   exec_state_t state_next;
   always_comb begin
      case (state_reg)
         ST_IDLE: state_next = wr_instr ? ST_EXEC : ST_IDLE;
         ST_EXEC: state_next =
            two_cycle ? ST_SECOND : ST_IDLE;
         ST_SECOND: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   wire exec_now = (state_reg == ST_EXEC);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         instr_reg <= 12'h000;
         cycles_reg <= 2'h0;
         illegal_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         busy_reg <= (state_next != ST_IDLE);
         if (wr_instr) begin
            // bit 11 rides on the same strobe as bits 10:8
            instr_reg <= {s_axi_wstrb_i[1] ? s_axi_wdata_i[11] :
                          instr_reg[11],
                          merge11(instr_reg[10:0], s_axi_wdata_i,
                                  s_axi_wstrb_i)};
         end
         if (exec_now) begin
            cycles_reg <= two_cycle ? CYCLES_TWO : CYCLES_ONE;
            illegal_reg <= (kind == K_ILLEGAL);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // architectural state

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_reg.acc <= ACC_RST;
         core_reg.status <= STATUS_RST;
         core_reg.pc <= PC_RST;
         stack_top_reg <= STACK_TOP_RST;
         config_reg <= CONFIG_RST;
      end else if (ce_i) begin
         if (exec_now) begin
            if (to_acc) begin
               core_reg.acc <= acc_value;
            end
            core_reg.status <= status_exec;
            core_reg.pc <= next_pc;
            if (kind == K_CONFIG_LOAD) begin
               config_reg <= acc;
            end
         end else begin
            if (wr_acc) begin
               core_reg.acc <= merge8(core_reg.acc, s_axi_wdata_i,
                                      s_axi_wstrb_i);
            end
            if (wr_status) begin
               core_reg.status <= merge8(core_reg.status, s_axi_wdata_i,
                                         s_axi_wstrb_i);
            end
            if (wr_pc) begin
               core_reg.pc <= merge11(core_reg.pc, s_axi_wdata_i,
                                      s_axi_wstrb_i);
            end
            if (wr_stack) begin
               stack_top_reg <= merge11(stack_top_reg, s_axi_wdata_i,
                                        s_axi_wstrb_i);
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 32; i++) begin
            rf_reg[i] <= FILE_RST;
         end
      end else if (ce_i) begin
         if (exec_now && to_file) begin
            rf_reg[f_addr] <= file_value;
         end else if (wr_file) begin
            rf_reg[wa[6:2]] <= merge8(rf_reg[wa[6:2]], s_axi_wdata_i,
                                      s_axi_wstrb_i);
         end
      end
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign busy_o = busy_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   chk_jump_target: assert property (
      exec_now && ce_i && kind == K_JUMP_ABS |=> core_reg.pc ==
      {$past(core_reg.status[PAGE_HI:PAGE_LO]), $past(jump_k)})
      else $error("jump target wrong");
   chk_jump_cycles: assert property (
      exec_now && ce_i && two_cycle
      |=> state_reg == ST_SECOND && $stable(core_reg.status))
      else $error("two-cycle timing or flags wrong");
   chk_or_lit: assert property (
      exec_now && ce_i && kind == K_OR_LIT
      |=> core_reg.acc == ($past(acc) | $past(lit)))
      else $error("or literal result wrong");
   chk_or_reg: assert property (
      exec_now && ce_i && kind == K_OR_REG && !dest_file
      |=> core_reg.acc == ($past(acc) | $past(f_val)))
      else $error("or register result wrong");
   chk_target_file: assert property (
      exec_now && ce_i && kind == K_COPY_REG && dest_file
      |=> $stable(core_reg.acc))
      else $error("file target touched acc");
   chk_store_acc: assert property (
      exec_now && ce_i && kind == K_STORE_ACC
      |=> rf_reg[$past(f_addr)] == $past(acc) && $stable(core_reg.status))
      else $error("store acc wrong");
   chk_load_lit: assert property (
      exec_now && ce_i && kind == K_LOAD_LIT
      |=> core_reg.acc == $past(lit) && $stable(core_reg.status))
      else $error("load literal wrong");
   chk_config_load: assert property (
      exec_now && ce_i && kind == K_CONFIG_LOAD
      |=> config_reg == $past(acc) && $stable(core_reg.status))
      else $error("config load wrong");
   chk_return_pc: assert property (
      exec_now && ce_i && kind == K_RETURN_LIT
      |=> core_reg.pc == $past(stack_top_reg) && core_reg.acc == $past(lit))
      else $error("return target wrong");
   chk_zero_flag: assert property (
      exec_now && ce_i && sets_zero
      |=> core_reg.status[ZERO_BIT] == ($past(result) == 8'h00))
      else $error("zero flag wrong");
   chk_nop_single: assert property (
      exec_now && ce_i && kind == K_NOP
      |=> state_reg == ST_IDLE && $stable(core_reg.acc))
      else $error("no-op not single cycle");

   cov_jump: cover property (exec_now && kind == K_JUMP_ABS);
   cov_return: cover property (exec_now && kind == K_RETURN_LIT);
   cov_copy_self: cover property (exec_now && kind == K_COPY_REG &&
                                  dest_file);

endmodule // instr_exec
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import instr_exec_pkg::*;

   typedef struct {
      string name;
      logic [31:0] data;
      logic [1:0] resp;
   } note_t;

   logic clock, rstn, busy;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int n_errors = 0;
   int samples_checked = 0;
   note_t notes[$];
   logic [7:0] acc_m, status_m, config_m;
   logic [10:0] pc_m;
   logic [7:0] file_m [32];

   instr_exec i_instr_exec (
      .clock_i(clock), .rstn_i(rstn), .ce_i(1'b1),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .busy_o(busy));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a hung handshake ends here instead of running forever
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      final_report();
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // responses are matched in issue order: one transfer at a time
   always @(posedge clock) begin : monitor
      note_t n;
      if ((bvalid === 1'b1 && bready === 1'b1) ||
          (rvalid === 1'b1 && rready === 1'b1)) begin
         if (notes.size() == 0) begin
            n_errors++;
            $display("ERROR response expected none seen one");
         end else begin
            n = notes.pop_front();
            if (rvalid === 1'b1) begin
               check(n.name, rdata, n.data);
               check({n.name, " rresp"}, {30'h0, rresp}, {30'h0, n.resp});
            end else begin
               check(n.name, {30'h0, bresp}, {30'h0, n.resp});
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] exp_resp);
      notes.push_back('{"bresp", 32'h0, exp_resp});
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clock); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge clock);
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                           input logic [1:0] exp_resp, input string n);
      notes.push_back('{n, exp, exp_resp});
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock);
      rready <= 1'b0;
   endtask

   task automatic set_zero(input logic [7:0] r);
      status_m[ZERO_BIT] = (r == 8'h00);
   endtask

   // issue one word, wait out busy, then compare exec, acc, status, pc, one file entry and config
   task automatic do_instr(input logic [11:0] w, input logic [1:0] cyc,
                           input logic [4:0] f);
      int n;
      axi_write(ADDR_INSTR, {20'h0, w}, 2'b00);
      // busy stands from the taken write for one cycle per step
      for (n = 0; n < 20 && busy === 1'b1; n++) @(posedge clock);
      check("busy cycles", n, {30'h0, cyc});
      axi_read(ADDR_EXEC, {28'h0, 1'b0, cyc, 1'b0}, 2'b00,
               "exec");
      axi_read(ADDR_ACC, {24'h0, acc_m}, 2'b00, "acc");
      axi_read(ADDR_STATUS, {24'h0, status_m}, 2'b00, "status");
      axi_read(ADDR_PC, {21'h0, pc_m}, 2'b00, "pc");
      axi_read(ADDR_FILE_BASE + {1'b0, f, 2'b00}, {24'h0, file_m[f]},
               2'b00, "file");
      axi_read(ADDR_CONFIG, {24'h0, config_m}, 2'b00, "config");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] k, r;
      logic [4:0] f, g;
      logic [1:0] pg;
      logic [10:0] st;
      logic [8:0] j;
      logic d;
      int seed;
      rstn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      acc_m = ACC_RST;
      status_m = STATUS_RST;
      pc_m = PC_RST;
      config_m = CONFIG_RST;
      foreach (file_m[i]) file_m[i] = FILE_RST;
      seed = $urandom(32'h7A2E);
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      axi_read(ADDR_STACK_TOP, {21'h0, STACK_TOP_RST}, 2'b00, "stack_top");
      axi_read(8'h1C, 32'h0, 2'b10, "unmapped");
      axi_write(8'h1C, 32'h0, 2'b10);
      for (int i = 0; i < 4; i++) begin
         k = (i == 0) ? 8'h00 : 8'($urandom);
         f = 5'($urandom);
         g = f ^ 5'h01;
         acc_m = k;
         pc_m++;
         do_instr({OP_LOAD_LIT, k}, CYCLES_ONE, f);
         r = (i == 0) ? 8'h00 : 8'($urandom);
         acc_m |= r;
         set_zero(acc_m);
         pc_m++;
         do_instr({OP_OR_LIT, r}, CYCLES_ONE, f);
         file_m[f] = acc_m;
         pc_m++;
         do_instr({OP_STORE_ACC, f}, CYCLES_ONE, f);
         k = (i == 0) ? 8'h00 : 8'($urandom);
         acc_m = k;
         pc_m++;
         do_instr({OP_LOAD_LIT, k}, CYCLES_ONE, f);
         d = i[0];
         r = acc_m | file_m[f];
         set_zero(r);
         pc_m++;
         if (d) file_m[f] = r;
         else acc_m = r;
         do_instr({OP_OR_REG, d, f}, CYCLES_ONE, f);
         // copy a neighbour so the zero flag gets to change
         d = ~d;
         r = file_m[g];
         set_zero(r);
         pc_m++;
         if (!d) acc_m = r;
         do_instr({OP_COPY_REG, d, g}, CYCLES_ONE, g);
         config_m = acc_m;
         pc_m++;
         do_instr(OP_CONFIG_LOAD, CYCLES_ONE, f);
         pg = 2'($urandom);
         status_m[PAGE_HI:PAGE_LO] = pg;
         axi_write(ADDR_STATUS, {24'h0, status_m}, 2'b00);
         j = (i == 0) ? 9'h1FF : 9'($urandom);
         pc_m = {pg, j};
         do_instr({OP_JUMP_ABS, j}, CYCLES_TWO,
                  f);
         st = 11'($urandom);
         axi_write(ADDR_STACK_TOP, {21'h0, st}, 2'b00);
         k = 8'($urandom);
         acc_m = k;
         pc_m = st;
         do_instr({OP_RETURN_LIT, k}, CYCLES_TWO, f);
         pc_m++;
         do_instr(OP_NOP, CYCLES_ONE, f);
      end
      // an unknown word runs as a no-op and raises the illegal flag
      pc_m++;
      axi_write(ADDR_INSTR, 32'h00000001, 2'b00);
      repeat (3) @(posedge clock);
      axi_read(ADDR_EXEC, {28'h0, 1'b1, CYCLES_ONE, 1'b0}, 2'b00,
               "illegal");
      axi_read(ADDR_PC, {21'h0, pc_m}, 2'b00, "pc");
      axi_read(ADDR_ACC, {24'h0, acc_m}, 2'b00, "acc");
      axi_read(ADDR_STATUS, {24'h0, status_m}, 2'b00, "status");
      repeat (3) @(posedge clock);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
